// [hdl/lct_consts.svh]
// constants for the logic capture, trigger and delay core
`ifndef LCT_CONSTS_SVH
`define LCT_CONSTS_SVH
`define LCT_DEPTH 256
`define LCT_CH 4
`define LCT_CNT_W 8
`define LCT_POST_1_8 8'hE0
`define LCT_POST_1_2 8'h80
`define LCT_POST_7_8 8'h20
`define LCT_CLK_HZ 100000000
`define LCT_INT_MIN_HZ 2000
`define LCT_INT_MAX_HZ 10000000
`define LCT_INT_DIV_MAX (`LCT_CLK_HZ / `LCT_INT_MIN_HZ)
`define LCT_INT_DIV_MIN (`LCT_CLK_HZ / `LCT_INT_MAX_HZ)
`define LCT_DIV_W 16
`define LCT_SYNC_LEN 8'h04
`define LCT_FIFO_DEPTH 4
`endif

// [hdl/lct_pkg.sv]
// types for the logic capture, trigger and delay core
package lct_pkg;
   typedef enum logic [1:0] {
      LCT_DLY_1_8,
      LCT_DLY_1_2,
      LCT_DLY_7_8
   } lct_delay_t;
   typedef enum logic [1:0] {
      LCT_TB_INT,
      LCT_TB_DUAL,
      LCT_TB_EXT
   } lct_tbase_t;
   typedef enum logic [1:0] {
      LCT_PM_DC,
      LCT_PM_HIGH,
      LCT_PM_LOW
   } lct_pmatch_t;
   typedef enum logic [2:0] {
      LCT_ST_IDLE,
      LCT_ST_ARMED,
      LCT_ST_POST,
      LCT_ST_DISPLAY,
      LCT_ST_READOUT
   } lct_state_t;
endpackage

// [hdl/lct_fifo.sv]
// small valid/ready fifo carrying readout words
module lct_fifo #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 4
) (
   input wire logic clock, // system clock
   input wire logic rst, // synchronous reset, high
   input wire logic in_valid, // write request
   output logic in_ready, // room for a word
   input wire logic [WIDTH-1:0] in_data, // word in
   output logic out_valid, // word available
   input wire logic out_ready, // consumer takes word
   output logic [WIDTH-1:0] out_data // head word
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rp_q];

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wp_q] <= in_data;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wp_q <= bump(wp_q);
         end
         if (pop) begin
            rp_q <= bump(rp_q);
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule

// [hdl/lct_core.sv]
// capture core: shift memory, trigger, post-trigger delay, display, readout
//
// Behaviour
// - each sample shifts into 256-deep memory
// - store one above threshold, zero below
// - record until trigger, then count down
// - one eighth delay: 224 samples after trigger
// - half delay: 128 samples after trigger
// - seven eighths delay: 32 samples after
// - dual base: internal, then external after trigger
// - internal 2 kHz to 10 MHz; external 14 MHz
// - after stop, recirculate memory for display
// - readout words first to last on request
// - readout word 4 bits with valid flag
// - sync pulse per sweep, optional inversion
// - free run: every sample triggers
// - pattern high/low/dontcare plus external bit
// - external trigger input is active low
`include "lct_consts.svh"
module lct_core #(
   parameter int FIFO_DEPTH = `LCT_FIFO_DEPTH
) (
   input wire logic clock, // 100 MHz system clock
   input wire logic rst, // synchronous reset, high
   input wire logic [3:0] comp_in, // comparator outputs, async
   input wire logic ext_clock_in, // external sample clock pin
   input wire logic ext_trig_n, // external trigger pin, low enables
   input wire logic start, // begin a new recording, pulse
   input wire logic free_run, // every sample is a trigger
   input wire lct_pkg::lct_pmatch_t pmatch [4], // pattern per channel
   input wire logic ext_trig_use, // external bit joins the pattern
   input wire lct_pkg::lct_delay_t post_trigger_count_select, // delay
   input wire lct_pkg::lct_tbase_t tbase, // time base mode
   input wire logic [15:0] int_div, // system clocks per internal sample
   input wire logic readout_mode, // digital output on request; display pauses only during the dump
   input wire logic read_req, // computer requests the dump
   input wire logic sync_invert, // invert sync polarity
   output logic recording, // samples being stored
   output logic triggered, // trigger seen this record
   output logic stopped, // storage halted
   output logic [3:0] disp_data, // recirculating memory output
   output logic sync_out, // sync pulse once per sweep
   output logic [3:0] rd_data, // readout word
   output logic rd_flag, // readout word valid
   input wire logic rd_ack // computer took the word
);
   import lct_pkg::*;

   // ==================================================================
   // input synchronisers
   logic [3:0] din_s1_q;
   logic [3:0] din_s2_q;
   logic [2:0] eck_q;
   logic [1:0] etr_q;

   always_ff @(posedge clock) begin
      if (rst) begin
         din_s1_q <= 4'h0;
         din_s2_q <= 4'h0;
         eck_q <= 3'h0;
         etr_q <= 2'h3;
      end else begin
         din_s1_q <= comp_in;
         din_s2_q <= din_s1_q;
         eck_q <= {eck_q[1:0], ext_clock_in};
         etr_q <= {etr_q[0], ext_trig_n};
      end
   end

   // edge taken from the second and third stages only
   logic ext_tick;
   assign ext_tick = eck_q[1] && !eck_q[2];

   // ==================================================================
   // internal time base divider
   logic [`LCT_DIV_W-1:0] div_q;
   logic [`LCT_DIV_W-1:0] div_lim;
   logic int_tick;

   // clamp the divide ratio to the supported internal range
   always_comb begin
      div_lim = int_div;
      if (int_div < `LCT_DIV_W'(`LCT_INT_DIV_MIN)) begin
         div_lim = `LCT_DIV_W'(`LCT_INT_DIV_MIN);
      end else if (int_div > `LCT_DIV_W'(`LCT_INT_DIV_MAX)) begin
         div_lim = `LCT_DIV_W'(`LCT_INT_DIV_MAX);
      end
   end

   assign int_tick = (div_q == div_lim - 1'b1);

   always_ff @(posedge clock) begin
      if (rst || int_tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end

   // ==================================================================
   // control state
   lct_state_t st_q;
   logic [`LCT_CNT_W-1:0] post_q;
   logic sample_tick;
   logic trig_hit;
   logic pat_ok;

   function automatic logic is_rec(input lct_state_t s);
      return (s == LCT_ST_ARMED) || (s == LCT_ST_POST);
   endfunction

   function automatic logic is_stop(input lct_state_t s);
      return (s == LCT_ST_DISPLAY) || (s == LCT_ST_READOUT);
   endfunction

   function automatic logic [`LCT_CNT_W-1:0] post_len(input lct_delay_t d);
      case (d)
         LCT_DLY_1_8: return `LCT_POST_1_8;
         LCT_DLY_1_2: return `LCT_POST_1_2;
         LCT_DLY_7_8: return `LCT_POST_7_8;
         default: return `LCT_POST_1_2;
      endcase
   endfunction

   // dual base switches only once the trigger has been seen
   always_comb begin
      case (tbase)
         LCT_TB_INT: sample_tick = int_tick;
         LCT_TB_EXT: sample_tick = ext_tick;
         LCT_TB_DUAL: sample_tick = (st_q == LCT_ST_POST) ?
            ext_tick : int_tick;
         default: sample_tick = int_tick;
      endcase
   end

   always_comb begin
      pat_ok = 1'b1;
      for (int i = 0; i < `LCT_CH; i++) begin
         case (pmatch[i])
            LCT_PM_HIGH: pat_ok = pat_ok && din_s2_q[i];
            LCT_PM_LOW: pat_ok = pat_ok && !din_s2_q[i];
            default: pat_ok = pat_ok;
         endcase
      end
      if (ext_trig_use && etr_q[1]) begin
         pat_ok = 1'b0;
      end
   end

   // only armed state looks at triggers
   assign trig_hit = (st_q == LCT_ST_ARMED) && sample_tick &&
      (free_run || pat_ok);

   logic rd_done;
   logic rd_pend_q;
   logic [`LCT_CNT_W-1:0] sweep_q;
   logic lap_end;

   // one display sweep is one full lap of the memory; at its end the
   // oldest word is back at the tail, which is where readout must start
   assign lap_end = (sweep_q == `LCT_CNT_W'(`LCT_DEPTH - 1));

   // a read request waits for the lap end, so readout never starts
   // mid-memory and never cuts a sync pulse short
   always_ff @(posedge clock) begin
      if (rst || start || st_q != LCT_ST_DISPLAY) begin
         rd_pend_q <= 1'b0;
      end else if (readout_mode && read_req) begin
         rd_pend_q <= 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst || start) begin
         post_q <= '0;
      end else if (trig_hit) begin
         post_q <= post_len(post_trigger_count_select);
      end else if (st_q == LCT_ST_POST && sample_tick) begin
         post_q <= post_q - 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_q <= LCT_ST_IDLE;
      end else if (start) begin
         st_q <= LCT_ST_ARMED;
      end else begin
         case (st_q)
            LCT_ST_IDLE: st_q <= LCT_ST_IDLE;
            LCT_ST_ARMED: begin
               if (trig_hit) begin
                  st_q <= LCT_ST_POST;
               end
            end
            LCT_ST_POST: begin
               if (sample_tick && post_q == `LCT_CNT_W'(1)) begin
                  st_q <= LCT_ST_DISPLAY;
               end
            end
            LCT_ST_DISPLAY: begin
               if (rd_pend_q && lap_end) begin
                  st_q <= LCT_ST_READOUT;
               end
            end
            LCT_ST_READOUT: begin
               if (rd_done) begin
                  st_q <= LCT_ST_DISPLAY;
               end
            end
            default: st_q <= LCT_ST_IDLE;
         endcase
      end
   end

   // ==================================================================
   // shift-register memory
   logic [3:0] mem_q [`LCT_DEPTH];
   logic storing;
   logic circ;
   logic fifo_ready;
   logic [`LCT_CNT_W-1:0] rd_cnt_q;
   logic rd_push;

   assign storing = is_rec(st_q) && sample_tick;
   // display recirculates every clock; readout steps on fifo room
   assign rd_push = (st_q == LCT_ST_READOUT) && fifo_ready;
   assign circ = (st_q == LCT_ST_DISPLAY) || rd_push;
   assign rd_done = rd_push && (rd_cnt_q == `LCT_CNT_W'(`LCT_DEPTH - 1));

   always_ff @(posedge clock) begin
      if (storing) begin
         mem_q[0] <= din_s2_q;
         for (int i = 1; i < `LCT_DEPTH; i++) begin
            mem_q[i] <= mem_q[i-1];
         end
      end else if (circ) begin
         mem_q[0] <= mem_q[`LCT_DEPTH-1];
         for (int i = 1; i < `LCT_DEPTH; i++) begin
            mem_q[i] <= mem_q[i-1];
         end
      end
   end

   // a full cycle of 256 shifts restores the original order, so the
   // oldest word always sits at the tail when readout begins
   always_ff @(posedge clock) begin
      if (rst || st_q != LCT_ST_READOUT) begin
         rd_cnt_q <= '0;
      end else if (rd_push) begin
         rd_cnt_q <= rd_cnt_q + 1'b1;
      end
   end

   // ==================================================================
   // display output and sweep sync
   logic sync_q;
   logic [3:0] disp_q;

   // sweep position counts display shifts; it wraps once per lap
   always_ff @(posedge clock) begin
      if (rst || st_q != LCT_ST_DISPLAY) begin
         sweep_q <= '0;
      end else begin
         sweep_q <= sweep_q + 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst || st_q != LCT_ST_DISPLAY) begin
         sync_q <= 1'b0;
      end else begin
         sync_q <= (sweep_q < `LCT_SYNC_LEN);
      end
   end

   always_ff @(posedge clock) begin
      if (rst || st_q != LCT_ST_DISPLAY) begin
         disp_q <= 4'h0;
      end else begin
         disp_q <= mem_q[`LCT_DEPTH-1];
      end
   end

   assign disp_data = disp_q;
   assign sync_out = sync_q ^ sync_invert;

   // ==================================================================
   // readout path; back-pressure from the fifo stalls the memory walk
   logic fifo_valid;
   logic [3:0] fifo_data;

   lct_fifo #(
      .WIDTH(`LCT_CH),
      .DEPTH(FIFO_DEPTH)
   ) i_lct_fifo (
      .clock(clock),
      .rst(rst || start),
      .in_valid(st_q == LCT_ST_READOUT),
      .in_ready(fifo_ready),
      .in_data(mem_q[`LCT_DEPTH-1]),
      .out_valid(fifo_valid),
      .out_ready(rd_ack),
      .out_data(fifo_data)
   );

   assign rd_flag = fifo_valid;
   assign rd_data = fifo_data;

   // ==================================================================
   // status
   logic trig_q;

   always_ff @(posedge clock) begin
      if (rst || start) begin
         trig_q <= 1'b0;
      end else if (trig_hit) begin
         trig_q <= 1'b1;
      end
   end

   assign triggered = trig_q;
   assign recording = is_rec(st_q);
   assign stopped = is_stop(st_q);
endmodule

// [verification/lct_core_asserts.sv]
// checker on the capture core ports
module lct_core_asserts (
   input wire logic clock, // system clock
   input wire logic rst, // sync reset
   input wire logic start, // new record
   input wire logic rd_ack, // word taken
   input wire logic sync_invert, // sync polarity
   input wire logic recording, // storing
   input wire logic triggered, // trigger seen
   input wire logic stopped, // halted
   input wire logic [3:0] disp_data, // display word
   input wire logic sync_out, // sync pulse
   input wire logic [3:0] rd_data, // readout word
   input wire logic rd_flag // readout valid
);
   timeunit 1ns;
   timeprecision 100ps;
   // =====
   // properties
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   wire logic sp = sync_out ^ sync_invert;
   sequence s_pulse;
      sp[*4] ##1 !sp;
   endsequence
   a_rec_stop_excl: assert property (!(recording && stopped))
      else $error("recording while stopped");
   a_disp_zero: assert property (!stopped && !$past(stopped) |->
      disp_data == 4'h0) else $error("display data outside display");
   a_flag_hold: assert property (rd_flag && !rd_ack && !start |=>
      rd_flag && $stable(rd_data)) else $error("word dropped unread");
   a_trig_holds: assert property (triggered && !start |=> triggered)
      else $error("trigger lost");
   a_stop_holds: assert property (stopped && !start |=> stopped)
      else $error("storage resumed");
   a_stop_after_trig: assert property ($rose(stopped) |-> triggered)
      else $error("stop without trigger");
   a_trig_when_rec: assert property ($rose(triggered) |-> recording)
      else $error("trigger outside recording");
   a_start_clears: assert property (start |=> !triggered && !stopped)
      else $error("start did not rearm");
   // a new recording may end the display in the middle of a pulse
   a_sync_width: assert property (disable iff (rst || start)
      $rose(sp) |-> s_pulse) else $error("sync pulse width");
endmodule

// [verification/lct_reader.sv]
// computer side model taking readout words
module lct_reader (
   input wire logic clock, // system clock
   input wire logic rst, // sync reset
   input wire logic stall, // hold off taking words
   input wire logic rd_flag, // word valid
   input wire logic [3:0] rd_data, // word
   output logic rd_ack // word taken
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] words [256];
   int count;
   initial rd_ack = 1'b0;
   // words are only taken at an edge where the flag is high
   always @(posedge clock) begin
      if (rst) count <= 0;
      else if (rd_flag && rd_ack) begin
         words[count[7:0]] <= rd_data;
         count <= count + 1;
      end
      rd_ack <= #1 !stall && !rst;
   end
endmodule

// [verification/lct_core_tb.sv]
// testbench for the capture core
module lct_core_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import lct_pkg::*;
   logic clock, rst, ext_clock_in, ext_trig_n, start, free_run, stall;
   logic ext_trig_use, readout_mode, read_req, sync_invert, sync_prev;
   logic recording, triggered, stopped, sync_out, rd_flag, rd_ack;
   logic [3:0] comp_in, disp_data, rd_data;
   logic [15:0] int_div;
   lct_pmatch_t pmatch [4];
   lct_delay_t dsel;
   lct_tbase_t tbase;
   int bad_count, n_compared, cycles, rises, lows;
   int post [3] = '{224, 128, 32};
   logic [3:0] hist [$];
   lct_core i_lct_core (.clock, .rst, .comp_in, .ext_clock_in,
      .ext_trig_n, .start, .free_run, .pmatch, .ext_trig_use,
      .post_trigger_count_select(dsel), .tbase, .int_div, .readout_mode,
      .read_req, .sync_invert, .recording, .triggered, .stopped,
      .disp_data, .sync_out, .rd_data, .rd_flag, .rd_ack);
   lct_reader i_lct_reader (.clock, .rst, .stall, .rd_flag, .rd_data,
      .rd_ack);
   // =====
   // tasks
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one external sample; data settles before the edge reaches the core
   task automatic sample(input logic [3:0] v);
      comp_in = v;
      hist.push_back(v);
      tick(4);
      ext_clock_in = 1'b1;
      tick(4);
      ext_clock_in = 1'b0;
      tick(4);
   endtask
   task automatic begin_rec(input lct_delay_t d, input logic fr);
      dsel = d;
      free_run = fr;
      start = 1'b1;
      tick(1);
      start = 1'b0;
      tick(2);
   endtask
   task automatic final_report;
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // =====
   // clock, timeout, sync counter
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (sync_out && !sync_prev) rises++;
      if (!sync_out) lows++;
      sync_prev <= sync_out;
      if (cycles == 40000) begin
         bad_count++;
         final_report();
      end
   end
   // =====
   // tests
   initial begin
      rst = 1'b1;
      comp_in = 4'h0;
      ext_clock_in = 1'b0;
      ext_trig_n = 1'b1;
      start = 1'b0;
      free_run = 1'b0;
      pmatch = '{LCT_PM_HIGH, LCT_PM_LOW, LCT_PM_DC, LCT_PM_DC};
      ext_trig_use = 1'b0;
      dsel = LCT_DLY_1_8;
      tbase = LCT_TB_EXT;
      int_div = 16'h000A;
      readout_mode = 1'b0;
      read_req = 1'b0;
      sync_invert = 1'b0;
      stall = 1'b0;
      sync_prev = 1'b0;
      tick(8);
      rst = 1'b0;
      chk(sync_out, 0);
      for (int d = 0; d < 3; d++) begin
         begin_rec(lct_delay_t'(d), 1'b1);
         sample(4'h0);
         chk(triggered, 1);
         repeat (post[d] - 1) sample(4'h0);
         chk(recording, 1);
         chk(stopped, 0);
         sample(4'h0);
         chk(stopped, 1);
      end
      read_req = 1'b1;
      tick(1);
      read_req = 1'b0;
      tick(10);
      chk(rd_flag, 0);
      $display("test delays done");
      tbase = LCT_TB_DUAL;
      begin_rec(LCT_DLY_7_8, 1'b1);
      tick(30);
      chk(triggered, 1);
      tick(600);
      chk(stopped, 0);
      repeat (32) sample(4'h0);
      chk(stopped, 1);
      rises = 0;
      tick(512);
      chk(rises, 2);
      sync_invert = 1'b1;
      tick(1);
      lows = 0;
      tick(256);
      chk(lows, 4);
      sync_invert = 1'b0;
      $display("test dual base done");
      tbase = LCT_TB_EXT;
      ext_trig_use = 1'b1;
      begin_rec(LCT_DLY_7_8, 1'b0);
      hist.delete();
      for (int k = 0; k < 300; k++) sample(k[3:0]);
      chk(triggered, 0);
      ext_trig_n = 1'b0;
      sample(4'h2);
      sample(4'h7);
      chk(triggered, 0);
      sample(4'hD);
      chk(triggered, 1);
      for (int k = 0; k < 32; k++) sample(4'hF - k[3:0]);
      chk(stopped, 1);
      readout_mode = 1'b1;
      stall = 1'b1;
      read_req = 1'b1;
      tick(1);
      read_req = 1'b0;
      tick(280);
      chk(rd_flag, 1);
      for (int i = 0; i < 5000 && i_lct_reader.count < 256; i++) begin
         stall = i[2];
         tick(1);
      end
      tick(10);
      chk(i_lct_reader.count, 256);
      chk(rd_flag, 0);
      chk(stopped, 1);
      for (int i = 0; i < 256; i++)
         chk(i_lct_reader.words[i], hist[hist.size() - 256 + i]);
      // each sweep shows the memory oldest first from the sync pulse on
      for (int i = 0; i < 300 && !(sync_out && !sync_prev); i++) tick(1);
      for (int i = 0; i < 256; i++) begin
         chk(disp_data, hist[hist.size() - 256 + i]);
         tick(1);
      end
      $display("test pattern readout done");
      final_report();
   end
endmodule

bind lct_core lct_core_asserts i_lct_core_asserts (.clock, .rst, .start,
   .rd_ack, .sync_invert, .recording, .triggered, .stopped, .disp_data,
   .sync_out, .rd_data, .rd_flag);
